// File: common/cfhs_pkg.sv
// Package of constants and carrier types for the charger fault/hold sequencer.
package cfhs_pkg;

    // Clock and tick timing.
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned TICK_US       = 1000;
    localparam int unsigned TICK_CYC      = CLK_HZ / 1_000_000 * TICK_US;
    localparam int unsigned TICK_W        = 15;

    // Timer lengths in ms ticks; hold lengths in minutes.
    localparam int unsigned TSD_DEB_MS    = 1;
    localparam int unsigned FB_DEB_MS     = 20;
    localparam int unsigned RETRY_MS      = 2000;
    localparam int unsigned DEAD_MS       = 2000;
    localparam int unsigned HOLD30_MIN    = 30;
    localparam int unsigned HOLD60_MIN    = 60;
    localparam int unsigned MS_PER_MIN    = 60_000;
    localparam int unsigned TMR_W         = 22;

    // Hold-configuration strap codes.
    localparam logic [1:0] HCFG_GND      = 2'h0;
    localparam logic [1:0] HCFG_MID      = 2'h1;
    localparam logic [1:0] HCFG_BIAS     = 2'h2;

    // Current class codes.
    localparam logic [1:0] DIV_2A4       = 2'h0;
    localparam logic [1:0] DIV_2A1       = 2'h1;
    localparam logic [1:0] DIV_1A0       = 2'h2;
    localparam logic [1:0] LIM_3A3       = 2'h0;
    localparam logic [1:0] LIM_2A75      = 2'h1;
    localparam logic [1:0] LIM_2A41      = 2'h2;
    localparam logic [1:0] LIM_2A1       = 2'h3;
    localparam logic [1:0] FB_NONE       = 2'h0;
    localparam logic [1:0] FB_2A41       = 2'h1;
    localparam logic [1:0] FB_2A1        = 2'h2;

    // Spread-spectrum trim span, in trim steps of 0.5 percent: +-3 percent.
    localparam logic signed [3:0] SS_SPAN = 4'sh6;

    typedef struct packed {
        logic [1:0] div_class;
        logic [1:0] port_limit;
        logic [1:0] foldback;
    } cfhs_current_limit_strap_t;

    typedef struct packed {
        logic switch_one;
        logic switch_two;
        logic gate_drive;
        logic data_switches;
        logic detect_run;
    } cfhs_port_t;

    typedef enum logic [1:0] {
        ST_RUN    = 2'b00,
        ST_FB_OFF = 2'b01,
        ST_TSD    = 2'b11
    } cfhs_state_t;

    typedef enum logic [1:0] {
        HS_IDLE   = 2'b00,
        HS_DEAD   = 2'b01,
        HS_ACTIVE = 2'b11,
        HS_OFF    = 2'b10
    } cfhs_hold_t;

endpackage : cfhs_pkg

// File: logic/cfhs_sequencer.sv
// Fault, hold and charge-detect sequencer for a dual-port dedicated charger.
`timescale 1ns/10ps
module cfhs_sequencer
    import cfhs_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC,
    parameter bit          SPREAD_EN   = 1'b0
) (
    // Clock and reset.
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    // Asynchronous comparator and pin inputs.
    input  wire logic        i_tsd_hot,
    input  wire logic        i_fb_hot,
    input  wire logic [1:0]  i_dm_high,
    input  wire logic [1:0]  i_dp_high,
    input  wire logic        i_host_port_enable,
    input  wire logic [1:0]  i_hold_strap,
    input  wire logic [2:0]  i_current_limit_strap,
    // Port and supply controls.
    output cfhs_port_t       o_port,
    output logic             o_converter_en,
    output logic             o_self_reset,
    output logic             o_port_discharge,
    output logic             o_hold_enable,
    output logic             o_power_off,
    // Data-line, limit and oscillator trim controls.
    output logic [1:0]       o_divider_connect,
    output logic [1:0]       o_line_short,
    output cfhs_current_limit_strap_t       o_current_limit_strap,
    output logic signed [3:0] o_osc_trim
);

    localparam int unsigned NSYNC = 7;

    // Three-stage synchronisers; a change is taken when stages two and three agree.
    logic [NSYNC-1:0] raw_w;
    logic [NSYNC-1:0] s1_q, s2_q, s3_q, filt_q;
    assign raw_w = {i_tsd_hot, i_fb_hot, i_dm_high, i_dp_high,
                    i_host_port_enable};
    genvar g;
    generate
        for (g = 0; g < NSYNC; g++) begin : g_sync
            always_ff @(posedge i_clk) begin
                s1_q[g] <= raw_w[g];
                s2_q[g] <= s1_q[g];
                s3_q[g] <= s2_q[g];
                // Reset takes the settled pin level, so an idle minus line
                // or a high host enable is not seen as a change afterwards.
                if (i_sys_rst) begin
                    filt_q[g] <= s3_q[g];
                end else if (s2_q[g] == s3_q[g]) begin
                    filt_q[g] <= s3_q[g];
                end
            end
        end
    endgenerate

    wire logic       tsd_w  = filt_q[6];
    wire logic       fb_w   = filt_q[5];
    wire logic [1:0] dm_w   = filt_q[4:3];
    wire logic [1:0] dp_w   = filt_q[2:1];
    wire logic       hen_w  = filt_q[0];

    // Millisecond tick divider.
    // shared tick
    logic [TICK_W-1:0] tdiv_q;
    wire logic tick_w = (tdiv_q == TICK_W'(TICK_CYCLES - 1));
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || tick_w) begin
            tdiv_q <= '0;
        end else begin
            tdiv_q <= tdiv_q + 1'b1;
        end
    end

    // Strap capture at boot; straps are static so one sample after reset.
    // boot capture
    logic        boot_q;
    logic [1:0]  hcfg_q;
    logic [2:0]  lcfg_q;
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            boot_q <= 1'b1;
            hcfg_q <= HCFG_GND;
            lcfg_q <= '0;
        end else if (boot_q) begin
            boot_q <= 1'b0;
            hcfg_q <= i_hold_strap;
            lcfg_q <= i_current_limit_strap;
        end
    end

    function automatic cfhs_current_limit_strap_t dec_current_limit_strap(input logic [2:0] c);
        unique case (c)
            3'h0: dec_current_limit_strap = '{DIV_2A4, LIM_3A3,  FB_NONE};
            3'h1: dec_current_limit_strap = '{DIV_2A4, LIM_3A3,  FB_2A41};
            3'h2: dec_current_limit_strap = '{DIV_2A4, LIM_3A3,  FB_2A1};
            3'h3: dec_current_limit_strap = '{DIV_2A4, LIM_2A75, FB_2A1};
            3'h4: dec_current_limit_strap = '{DIV_2A4, LIM_2A75, FB_NONE};
            3'h5: dec_current_limit_strap = '{DIV_2A1, LIM_2A41, FB_NONE};
            3'h6: dec_current_limit_strap = '{DIV_2A1, LIM_2A41, FB_2A1};
            3'h7: dec_current_limit_strap = '{DIV_1A0, LIM_2A1,  FB_NONE};
        endcase
    endfunction : dec_current_limit_strap

    function automatic logic [TMR_W-1:0] hold_ms(input logic [1:0] c);
        if (c == HCFG_MID) begin
            hold_ms = TMR_W'(HOLD30_MIN * MS_PER_MIN);
        end else if (c == HCFG_BIAS) begin
            hold_ms = TMR_W'(HOLD60_MIN * MS_PER_MIN);
        end else begin
            hold_ms = '0;
        end
    endfunction : hold_ms

    wire cfhs_current_limit_strap_t strap_current_limit_strap_w = dec_current_limit_strap(lcfg_q);
    wire logic       hold_on_w    = (hcfg_q == HCFG_MID) ||
                                    (hcfg_q == HCFG_BIAS);

    // Thermal state machine.
    cfhs_state_t       st_q, st_d;
    logic [TMR_W-1:0]  deb_q, ret_q;
    wire logic tsd_done_w = tsd_w && (deb_q >= TMR_W'(TSD_DEB_MS));
    wire logic fb_done_w  = fb_w && (deb_q >= TMR_W'(FB_DEB_MS));
    wire logic ret_done_w = !fb_w && (ret_q >= TMR_W'(RETRY_MS));

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_RUN: begin
                if (tsd_done_w) begin
                    st_d = ST_TSD;
                end else if (fb_done_w) begin
                    st_d = ST_FB_OFF;
                end
            end
            ST_FB_OFF: begin
                if (tsd_done_w) begin
                    st_d = ST_TSD;
                end else if (ret_done_w) begin
                    st_d = ST_RUN;
                end
            end
            ST_TSD: st_d = ST_TSD;
            default: st_d = ST_RUN;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st_q  <= ST_RUN;
            deb_q <= '0;
            ret_q <= '0;
        end else begin
            st_q <= st_d;
            if (!tsd_w && !fb_w) begin
                deb_q <= '0;
            end else if (tick_w) begin
                deb_q <= deb_q + 1'b1;
            end
            if (fb_w || st_q != ST_FB_OFF) begin
                ret_q <= '0;
            end else if (tick_w) begin
                ret_q <= ret_q + 1'b1;
            end
        end
    end

    // Hold-mode sequencer with discharge dead time.
    cfhs_hold_t       hs_q, hs_d;
    logic [TMR_W-1:0] hold_q, dead_q;
    logic             hen_prev_q;
    wire logic hen_edge_w = (hen_w != hen_prev_q);
    wire logic dead_end_w = (dead_q >= TMR_W'(DEAD_MS));
    wire logic hold_end_w = (hold_q >= hold_ms(hcfg_q));

    always_comb begin
        hs_d = hs_q;
        unique case (hs_q)
            HS_IDLE: if (!boot_q && hold_on_w) hs_d = HS_ACTIVE;
            HS_DEAD: if (dead_end_w) hs_d = HS_ACTIVE;
            HS_ACTIVE: begin
                if (hold_end_w) begin
                    hs_d = HS_OFF;
                end else if (hen_edge_w) begin
                    hs_d = HS_DEAD;
                end
            end
            HS_OFF: hs_d = HS_OFF;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            hs_q       <= HS_IDLE;
            hold_q     <= '0;
            dead_q     <= '0;
            hen_prev_q <= 1'b0;
        end else begin
            hs_q       <= hs_d;
            hen_prev_q <= hen_w;
            if (hs_q == HS_IDLE) begin
                hold_q <= '0;
            end else if (tick_w && hs_q != HS_OFF) begin
                hold_q <= hold_q + 1'b1;
            end
            if (hs_q != HS_DEAD) begin
                dead_q <= '0;
            end else if (tick_w) begin
                dead_q <= dead_q + 1'b1;
            end
        end
    end

    // Port paths; thermal faults override, discharge gates the switches.
    // shutdown action
    wire logic paths_ok_w = (st_q == ST_RUN);
    wire logic in_hold_w  = (hs_q == HS_DEAD) || (hs_q == HS_ACTIVE);
    wire logic power_w    = !hold_on_w || in_hold_w || hs_q == HS_IDLE;
    wire logic sw_on_w    = paths_ok_w && (hs_q != HS_DEAD) && power_w;
    wire logic det_on_w   = paths_ok_w && power_w;

    // Data-line detection per port.
    logic [1:0] short_q;

    // Spread-spectrum triangle dither of the oscillator trim.
    logic signed [3:0] trim_q;
    logic              up_q;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_port           <= '0;
            o_converter_en   <= 1'b0;
            o_self_reset     <= 1'b0;
            o_port_discharge <= 1'b0;
            o_hold_enable    <= 1'b0;
            o_power_off      <= 1'b0;
            o_divider_connect<= '0;
            o_line_short     <= '0;
            o_current_limit_strap           <= '0;
            short_q          <= '0;
            trim_q           <= '0;
            up_q             <= 1'b1;
        end else begin
            o_port.switch_one    <= sw_on_w;
            o_port.switch_two    <= sw_on_w;
            o_port.gate_drive    <= sw_on_w;
            o_port.data_switches <= sw_on_w;
            o_port.detect_run    <= det_on_w;
            o_converter_en       <= (st_q != ST_TSD) && power_w;
            o_self_reset         <= (st_q == ST_TSD);
            o_port_discharge     <= (hs_q == HS_DEAD);
            o_hold_enable        <= in_hold_w;
            o_power_off          <= (hs_q == HS_OFF);
            o_current_limit_strap               <= strap_current_limit_strap_w;
            if (st_q == ST_FB_OFF && strap_current_limit_strap_w.foldback != FB_NONE) begin
                o_current_limit_strap.port_limit <= (strap_current_limit_strap_w.foldback == FB_2A41) ?
                                     LIM_2A41 : LIM_2A1;
            end
            for (int p = 0; p < 2; p++) begin
                if (!det_on_w) begin
                    short_q[p] <= 1'b0;
                end else if (!dm_w[p] || dp_w[p]) begin
                    short_q[p] <= 1'b1;
                end
            end
            o_divider_connect <= det_on_w ? ~short_q : 2'h0;
            o_line_short      <= det_on_w ? short_q : 2'h0;
            if (SPREAD_EN && tick_w) begin
                if (up_q && trim_q == SS_SPAN) begin
                    up_q <= 1'b0;
                end else if (!up_q && trim_q == -SS_SPAN) begin
                    up_q <= 1'b1;
                end else begin
                    trim_q <= up_q ? trim_q + 4'sh1 : trim_q - 4'sh1;
                end
            end
        end
    end
    assign o_osc_trim = trim_q;

endmodule : cfhs_sequencer

// File: verification/cfhs_monitor.sv
// Port-level checker for the charger fault and hold sequencer.
`timescale 1ns/10ps
module cfhs_monitor
    import cfhs_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC
) (
    input wire logic              i_clk,
    input wire logic              i_sys_rst,
    input wire logic              i_tsd_hot,
    input wire logic              i_fb_hot,
    input wire logic              i_host_port_enable,
    input wire cfhs_port_t        o_port,
    input wire logic              o_converter_en,
    input wire logic              o_self_reset,
    input wire logic              o_port_discharge,
    input wire logic              o_hold_enable,
    input wire logic              o_power_off,
    input wire logic [1:0]        o_divider_connect,
    input wire logic [1:0]        o_line_short,
    input wire logic signed [3:0] o_osc_trim
);
    localparam int RETRY_CYC = RETRY_MS * TICK_CYCLES;
    int fb_low_d;
    int fb_low_q;
    // Reset loads a full count so the first enable after boot is no retry.
    assign fb_low_d = i_sys_rst ? RETRY_CYC : i_fb_hot ? 0 :
                      (fb_low_q < RETRY_CYC) ? fb_low_q + 1 : fb_low_q;
    always_ff @(posedge i_clk) begin
        fb_low_q <= fb_low_d;
    end
    default clocking mon_cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    sequence host_edge_s;
        $changed(i_host_port_enable) && o_hold_enable && !o_power_off;
    endsequence
    sequence fb_cause_s;
        $past(i_fb_hot, 4);
    endsequence
    sequence other_off_s;
        ##[0:2] (o_port_discharge || o_self_reset);
    endsequence
    tsd_all_off_a: assert property (
        o_self_reset && $past(o_self_reset) |-> !o_converter_en && o_port == 5'h00)
        else $error("outputs on during shutdown");
    tsd_sticky_a: assert property (o_self_reset |=> o_self_reset)
        else $error("shutdown state left without reset");
    tsd_cause_a: assert property (
        $rose(o_self_reset) |-> $past(i_tsd_hot, 4))
        else $error("shutdown without a hot input");
    fb_cause_a: assert property (
        $fell(o_port.switch_one) && !o_power_off |-> fb_cause_s or other_off_s)
        else $error("port switched off without cause");
    retry_wait_a: assert property (
        $rose(o_port.switch_one) && !$past(o_port_discharge)
        && !$past(o_port_discharge, 2) |-> fb_low_q >= RETRY_CYC - 2 * TICK_CYCLES)
        else $error("port restored before retry time");
    dead_start_a: assert property (host_edge_s |-> ##[1:10] o_port_discharge)
        else $error("no discharge after host enable edge");
    dead_off_a: assert property (
        o_port_discharge && $past(o_port_discharge) |->
        !o_port.switch_one && !o_port.switch_two && o_port.detect_run)
        else $error("switch on or detection off in dead time");
    line_excl_a: assert property ((o_divider_connect & o_line_short) == 2'h0)
        else $error("divider and short both on");
    short_latch_a: assert property (
        $fell(o_line_short[0]) |-> !o_port.detect_run || !$past(o_port.detect_run))
        else $error("line short dropped while detecting");
    trim_span_a: assert property (o_osc_trim <= SS_SPAN && o_osc_trim >= -SS_SPAN)
        else $error("trim outside span");
    power_sticky_a: assert property (o_power_off |=> o_power_off && !o_hold_enable)
        else $error("hold enable kept after power off");
endmodule : cfhs_monitor

bind cfhs_sequencer cfhs_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon_u (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_tsd_hot(i_tsd_hot),
    .i_fb_hot(i_fb_hot), .i_host_port_enable(i_host_port_enable),
    .o_port(o_port), .o_converter_en(o_converter_en),
    .o_self_reset(o_self_reset), .o_port_discharge(o_port_discharge),
    .o_hold_enable(o_hold_enable), .o_power_off(o_power_off),
    .o_divider_connect(o_divider_connect), .o_line_short(o_line_short),
    .o_osc_trim(o_osc_trim)
);

// File: verification/cfhs_port_model.sv
// Portable device on each charging port, seen through the line comparators.
`timescale 1ns/10ps
module cfhs_port_model (
    // Per-port requests to pull plus up or minus down.
    input  wire logic [1:0] i_plus_pull,
    input  wire logic [1:0] i_minus_pull,
    // Comparator views of the data lines.
    output wire logic [1:0] o_dm_high,
    output wire logic [1:0] o_dp_high
);
    // An idle device leaves the charger bias: minus high, plus low.
    assign o_dm_high = ~i_minus_pull;
    assign o_dp_high = i_plus_pull;
endmodule : cfhs_port_model

// File: verification/cfhs_sequencer_bench.sv
// Directed bench for the charger fault and hold sequencer.
`timescale 1ns/10ps
module cfhs_sequencer_bench
    import cfhs_pkg::*;
;
    localparam int unsigned TK = 4;
    localparam int T2S = RETRY_MS * TK;
    logic i_clk = 1'b0, i_sys_rst = 1'b1, i_tsd_hot = 1'b0, i_fb_hot = 1'b0;
    logic i_host_port_enable = 1'b1;
    logic [1:0] i_hold_strap = 2'h0, plus_pull = 2'h0, minus_pull = 2'h0;
    logic [2:0] i_current_limit_strap = 3'h0;
    wire logic [1:0] i_dm_high, i_dp_high;
    cfhs_port_t o_port;
    cfhs_current_limit_strap_t o_current_limit_strap;
    logic o_converter_en, o_self_reset, o_port_discharge, o_hold_enable;
    logic o_power_off;
    logic [1:0] o_divider_connect, o_line_short;
    logic signed [3:0] o_osc_trim;
    int err_count = 0;
    int n_tests = 0;
    logic [5:0] lim_tbl [8] = '{{DIV_2A4, LIM_3A3, FB_NONE},
        {DIV_2A4, LIM_3A3, FB_2A41}, {DIV_2A4, LIM_3A3, FB_2A1},
        {DIV_2A4, LIM_2A75, FB_2A1}, {DIV_2A4, LIM_2A75, FB_NONE},
        {DIV_2A1, LIM_2A41, FB_NONE}, {DIV_2A1, LIM_2A41, FB_2A1},
        {DIV_1A0, LIM_2A1, FB_NONE}};
    cfhs_port_model dev_u (.i_plus_pull(plus_pull), .i_minus_pull(minus_pull),
        .o_dm_high(i_dm_high), .o_dp_high(i_dp_high));
    cfhs_sequencer #(.TICK_CYCLES(TK), .SPREAD_EN(1'b1)) dut_u (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_tsd_hot(i_tsd_hot),
        .i_fb_hot(i_fb_hot), .i_dm_high(i_dm_high), .i_dp_high(i_dp_high),
        .i_host_port_enable(i_host_port_enable), .i_hold_strap(i_hold_strap),
        .i_current_limit_strap(i_current_limit_strap), .o_port(o_port),
        .o_converter_en(o_converter_en), .o_self_reset(o_self_reset),
        .o_port_discharge(o_port_discharge), .o_hold_enable(o_hold_enable),
        .o_power_off(o_power_off), .o_divider_connect(o_divider_connect),
        .o_line_short(o_line_short), .o_current_limit_strap(o_current_limit_strap), .o_osc_trim(o_osc_trim));
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #2;
    endtask : tick
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic boot(input logic [1:0] hold, input logic [2:0] lim);
        i_sys_rst = 1'b1;
        i_hold_strap = hold;
        i_current_limit_strap = lim;
        tick(6);
        i_sys_rst = 1'b0;
        tick(10);
    endtask : boot
    task automatic wait_idle(input logic want_port);
        int i;
        for (i = 0; i < 400; i++) begin
            if (want_port ? o_port === 5'h1f : o_port_discharge === 1'b0) break;
            tick(1);
        end
        if (i == 400) begin
            err_count++;
            summarize();
        end
    endtask : wait_idle
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    initial begin
        forever #25 i_clk = ~i_clk;
    end
    initial begin
        repeat (60000) @(posedge i_clk);
        err_count++;
        summarize();
    end
    initial begin
        int k;
        for (k = 0; k < 8; k++) begin
            boot(2'(k % 3), 3'(k));
            chk({2'h0, o_current_limit_strap}, {2'h0, lim_tbl[k]});
            chk({7'h0, o_hold_enable}, {7'h0, k % 3 != 0});
        end
        boot(2'h0, 3'h1);
        chk({6'h0, o_divider_connect}, 8'h03);
        plus_pull = 2'h1;
        minus_pull = 2'h2;
        tick(12);
        chk({6'h0, o_line_short, o_divider_connect}, 8'h0c);
        plus_pull = 2'h0;
        minus_pull = 2'h0;
        tick(12);
        chk({6'h0, o_line_short}, 8'h03);
        // Two 60-cycle bursts trip an 80-cycle debounce only if summed.
        repeat (2) begin
            i_fb_hot = 1'b1;
            tick(60);
            i_fb_hot = 1'b0;
            tick(20);
        end
        chk({3'h0, o_port}, 8'h1f);
        i_fb_hot = 1'b1;
        tick(120);
        chk({3'h0, o_port}, 8'h00);
        chk({4'h0, o_current_limit_strap.port_limit, o_line_short}, {4'h0, LIM_2A41, 2'h0});
        i_fb_hot = 1'b0;
        tick(T2S - 60);
        chk({3'h0, o_port}, 8'h00);
        wait_idle(1'b1);
        tick(4);
        chk({2'h0, o_current_limit_strap}, {2'h0, lim_tbl[1]});
        chk({6'h0, o_divider_connect}, 8'h03);
        i_tsd_hot = 1'b1;
        tick(20);
        chk({1'h0, o_port, o_converter_en, o_self_reset}, 8'h01);
        i_tsd_hot = 1'b0;
        boot(HCFG_MID, 3'h0);
        i_hold_strap = HCFG_GND;
        i_host_port_enable = 1'b0;
        tick(20);
        chk({5'h0, o_hold_enable, o_port_discharge, o_port.switch_one}, 8'h06);
        chk({7'h0, o_port.detect_run}, 8'h01);
        tick(T2S - 60);
        chk({7'h0, o_port_discharge}, 8'h01);
        wait_idle(1'b0);
        i_host_port_enable = 1'b1;
        tick(20);
        chk({7'h0, o_port_discharge}, 8'h01);
        tick(T2S - 60);
        chk({7'h0, o_port_discharge}, 8'h01);
        wait_idle(1'b0);
        tick(4);
        chk({5'h0, o_port.switch_one, o_hold_enable, o_power_off}, 8'h06);
        // The dither must reach its upper bound within a few turns.
        for (k = 0; k < 200 && o_osc_trim !== SS_SPAN; k++) begin
            tick(1);
        end
        chk({4'h0, o_osc_trim}, {4'h0, SS_SPAN});
        summarize();
    end
endmodule : cfhs_sequencer_bench
